// file: hw/pll_fast_lock_sequencer.v
// The implementer's own choices: the register addresses and the APB register port.
`include "pll_fast_lock_regs.vh"
module pll_fast_lock_sequencer #(
  parameter DIV_RATIO   = `DIV_RATIO,
  parameter MEAS_CYCLES = `MEAS_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // detector inputs (asynchronous pins)
  input  wire        referenceInput,
  input  wire        feedbackInput,
  // charge pump drive
  output reg         loopUpOut,
  output reg         loopDownOut,
  output reg  [3:0]  loopScaleOut,
  output reg         fastLockUpOut,
  output reg         fastLockDownOut,
  output reg  [5:0]  fastLockScaleOut,
  output reg  [2:0]  driveStateOut
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [1:0] refSync_r;
  reg [1:0] fbSync_r;
  reg       refLast_r;
  reg       fbLast_r;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refSync_r <= 2'h0;
      fbSync_r  <= 2'h0;
      refLast_r <= 1'b0;
      fbLast_r  <= 1'b0;
    end
    else
    begin
      refSync_r <= {refSync_r[0], referenceInput};
      fbSync_r  <= {fbSync_r[0], feedbackInput};
      refLast_r <= refSync_r[1];
      fbLast_r  <= fbSync_r[1];
    end
  end
  wire refRise = refSync_r[1] & ~refLast_r;
  wire fbRise  = fbSync_r[1] & ~fbLast_r;

  // ************************************************************
  // control_function_register and APB
  // ************************************************************
  reg [31:0] ctrl_r;
  wire       apbAccess = psel & penable;
  wire       addrOk    = (paddr == `CTRL_ADDR) | (paddr == `STATUS_ADDR) |
                         (paddr == `EDGECNT_ADDR);
  wire [1:0] finalSel  = ctrl_r[`CTRL_FINAL_LSB +: 2];
  wire [2:0] wideSel   = ctrl_r[`CTRL_WIDE_LSB +: 3];
  wire [1:0] fdetSel   = ctrl_r[`CTRL_FDET_LSB +: 2];
  wire       polarity  = ctrl_r[`CTRL_POL_BIT];
  wire       offsetOn  = ctrl_r[`CTRL_OFFSET_BIT];
  wire [7:0] lockCount = ctrl_r[`CTRL_LOCKCNT_LSB +: 8];
  wire [7:0] bigDiff   = ctrl_r[`CTRL_FBIG_LSB +: 8];

  reg [2:0]  state_r;
  reg [7:0]  lastDiff_r;
  reg        phaseLock_r;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r  <= `CTRL_RESET;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // one wait state: pready rises in the first access cycle's next edge
      pready  <= apbAccess & ~pready;
      pslverr <= apbAccess & ~pready & ~addrOk;
      // the write lands on the edge that completes the transfer
      if (apbAccess & pready & pwrite & (paddr == `CTRL_ADDR))
        ctrl_r <= pwdata;
      if (apbAccess & ~pready)
      begin
        case (paddr)
          `CTRL_ADDR:    prdata <= ctrl_r;
          `STATUS_ADDR:  prdata <= {28'h0000000, phaseLock_r, state_r};
          `EDGECNT_ADDR: prdata <= {24'h000000, lastDiff_r};
          default:       prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ************************************************************
  // divider: one-cycle enable at sample clock / 8
  // ************************************************************
  reg [3:0] divCnt_r;
  wire      slowTick = (divCnt_r == DIV_RATIO - 1);
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      divCnt_r <= 4'h0;
    else if (slowTick)
      divCnt_r <= 4'h0;
    else
      divCnt_r <= divCnt_r + 4'h1;
  end

  // ************************************************************
  // frequency comparison over a measurement interval
  // ************************************************************
  // edges are caught every cycle but latched per slow tick so the
  // comparator itself only advances on the enable
  reg        refSeen_r;
  reg        fbSeen_r;
  reg [4:0]  measCnt_r;
  reg [7:0]  refCnt_r;
  reg [7:0]  fbCnt_r;
  wire       intervalEnd = slowTick & (measCnt_r == MEAS_CYCLES - 1);

  function [7:0] absDiff;
    input [7:0] a;
    input [7:0] b;
    begin
      absDiff = (a > b) ? a - b : b - a;
    end
  endfunction

  function [7:0] sat;
    input [7:0] v;
    input       inc;
    begin
      sat = (inc && v != 8'hFF) ? v + 8'h01 : v;
    end
  endfunction

  wire [7:0] refFinal = sat(refCnt_r, refSeen_r);
  wire [7:0] fbFinal  = sat(fbCnt_r, fbSeen_r);
  wire [7:0] diffNow  = absDiff(refFinal, fbFinal);
  wire       fbFaster = fbFinal > refFinal;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refSeen_r  <= 1'b0;
      fbSeen_r   <= 1'b0;
      measCnt_r  <= 5'h00;
      refCnt_r   <= 8'h00;
      fbCnt_r    <= 8'h00;
      lastDiff_r <= 8'h00;
    end
    else
    begin
      refSeen_r <= slowTick ? refRise : (refSeen_r | refRise);
      fbSeen_r  <= slowTick ? fbRise : (fbSeen_r | fbRise);
      if (slowTick)
      begin
        if (intervalEnd)
        begin
          measCnt_r  <= 5'h00;
          refCnt_r   <= 8'h00;
          fbCnt_r    <= 8'h00;
          lastDiff_r <= diffNow;
        end
        else
        begin
          measCnt_r <= measCnt_r + 5'h01;
          refCnt_r  <= refFinal;
          fbCnt_r   <= fbFinal;
        end
      end
    end
  end

  // ************************************************************
  // phase lock detector: consecutive edge pairs close together
  // ************************************************************
  reg [7:0] lockRun_r;
  reg [2:0] gap_r;
  reg       pend_r;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_r       <= 3'h7;
      lockRun_r   <= 8'h00;
      pend_r      <= 1'b0;
      phaseLock_r <= 1'b0;
    end
    else
    begin
      if (refRise ^ fbRise)
        gap_r <= 3'h0;
      else if (gap_r != 3'h7)
        gap_r <= gap_r + 3'h1;
      // a lone edge opens a pair; it must not clear the run, only its timeout may
      if ((refRise & fbRise) | ((refRise ^ fbRise) & pend_r))
        lockRun_r <= sat(lockRun_r, 1'b1);
      else if (pend_r && gap_r == 3'h6)
        lockRun_r <= 8'h00;
      if (refRise | fbRise)
        pend_r <= (refRise ^ fbRise) & ~pend_r;
      else if (gap_r == 3'h6)
        pend_r <= 1'b0;
      phaseLock_r <= (lockRun_r >= lockCount);
    end
  end

  // ************************************************************
  // drive state sequencer
  // ************************************************************
  // big difference enters detect; small difference in detect is
  // frequency lock; all moves wait for interval end
  reg [2:0] state_nxt;
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ST_FDET:
        if (intervalEnd && diffNow < bigDiff)
          state_nxt = (wideSel == 3'h0) ? `ST_FINAL : `ST_WIDE;
      `ST_WIDE:
        if (intervalEnd && diffNow >= bigDiff)
          state_nxt = `ST_FDET;
        else if (intervalEnd && phaseLock_r)
          state_nxt = `ST_FINAL;
      `ST_FINAL:
        if (intervalEnd && diffNow >= bigDiff)
          state_nxt = `ST_FDET;
      default:
        state_nxt = `ST_FINAL;
    endcase
  end

  reg fdetDirUp_r;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= `ST_FINAL;
      fdetDirUp_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (intervalEnd)
        fdetDirUp_r <= ~fbFaster; // slow feedback needs higher tune voltage
    end
  end

  // ************************************************************
  // phase frequency detector
  // ************************************************************
  reg pfdUp_r;
  reg pfdDown_r;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pfdUp_r   <= 1'b0;
      pfdDown_r <= 1'b0;
    end
    else if ((pfdUp_r | refRise) & (pfdDown_r | fbRise))
    begin
      pfdUp_r   <= 1'b0;
      pfdDown_r <= 1'b0;
    end
    else
    begin
      pfdUp_r   <= pfdUp_r | refRise;
      pfdDown_r <= pfdDown_r | fbRise;
    end
  end

  // ************************************************************
  // output drive
  // ************************************************************
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loopUpOut        <= 1'b0;
      loopDownOut      <= 1'b0;
      loopScaleOut     <= 4'h0;
      fastLockUpOut    <= 1'b0;
      fastLockDownOut  <= 1'b0;
      fastLockScaleOut <= 6'h00;
      driveStateOut    <= `ST_FINAL;
    end
    else
    begin
      driveStateOut <= state_r;
      if (state_r == `ST_FDET)
      begin
        loopUpOut        <= 1'b0;
        loopDownOut      <= 1'b0;
        loopScaleOut     <= 4'h0;
        fastLockUpOut    <= fdetDirUp_r ^ polarity;
        fastLockDownOut  <= ~fdetDirUp_r ^ polarity;
        fastLockScaleOut <= {4'h0, fdetSel} * 6'h14;
      end
      else
      begin
        fastLockUpOut    <= 1'b0;
        fastLockDownOut  <= 1'b0;
        fastLockScaleOut <= 6'h00;
        loopUpOut        <= polarity ? pfdDown_r : pfdUp_r;
        loopDownOut      <= polarity ? pfdUp_r : pfdDown_r;
        if (state_r == `ST_WIDE)
          loopScaleOut <= {wideSel, 1'b0};
        else
          loopScaleOut <= {1'b0, offsetOn, finalSel} + 4'h1;
      end
    end
  end

endmodule

// file: hw/pll_fast_lock_regs.vh
`ifndef PLL_FAST_LOCK_REGS_VH
`define PLL_FAST_LOCK_REGS_VH

// ************************************************************
// register map (APB byte addresses)
// ************************************************************
`define CTRL_ADDR        12'h000
`define STATUS_ADDR      12'h004
`define EDGECNT_ADDR     12'h008
// control_function_register field positions
`define CTRL_FINAL_LSB   0
`define CTRL_WIDE_LSB    2
`define CTRL_FDET_LSB    5
`define CTRL_POL_BIT     10
`define CTRL_OFFSET_BIT  13
`define CTRL_LOCKCNT_LSB 16
`define CTRL_FBIG_LSB    24
`define CTRL_RESET       32'h0A020000
// ************************************************************
// timing
// ************************************************************
`define DIV_RATIO        8
`define MEAS_CYCLES      19
// drive states, one-hot
`define ST_FDET          3'h1
`define ST_WIDE          3'h2
`define ST_FINAL         3'h4
`endif

// file: bench/pll_seq_props.sv
`include "pll_fast_lock_regs.vh"
module pll_seq_props #(
  parameter DIV_RATIO   = `DIV_RATIO,
  parameter MEAS_CYCLES = `MEAS_CYCLES
) (
  // clock, reset, bus
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // pump drive
  input wire logic       loopUpOut,
  input wire logic       loopDownOut,
  input wire logic [3:0] loopScaleOut,
  input wire logic       fastLockUpOut,
  input wire logic       fastLockDownOut,
  input wire logic [5:0] fastLockScaleOut,
  input wire logic [2:0] driveStateOut
);
  localparam int PERIOD = DIV_RATIO * MEAS_CYCLES;
  logic [2:0] lastState_r;
  int         gap_r;
  wire        moved = driveStateOut != lastState_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************
  // change spacing
  // ****************
  // zero means no change seen yet, so the first change is not judged
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lastState_r <= `ST_FINAL;
      gap_r       <= 0;
    end
    else
    begin
      lastState_r <= driveStateOut;
      gap_r       <= moved ? 1 : (gap_r == 0 ? 0 : gap_r + 1);
    end
  end
  sequence setupPhase; psel && !penable; endsequence
  sequence accessPhase; psel && penable; endsequence
  a_state_onehot:
    assert property ($onehot(driveStateOut)) else $error("state not one-hot");
  a_detect_path:
    assert property (driveStateOut == `ST_FDET |-> !loopUpOut && !loopDownOut)
    else $error("loop drive in detect");
  a_loop_path:
    assert property (driveStateOut != `ST_FDET |-> !fastLockUpOut && !fastLockDownOut)
    else $error("fast drive outside detect");
  a_pump_single:
    assert property (!(loopUpOut && loopDownOut)) else $error("pump up and down together");
  a_detect_drive:
    assert property ((driveStateOut == `ST_FDET && fastLockScaleOut != 6'h00)[*2]
      |-> fastLockUpOut != fastLockDownOut) else $error("detect drive not single");
  a_detect_scale:
    assert property (fastLockScaleOut inside {6'h00, 6'h14, 6'h28, 6'h3C})
    else $error("bad detect scale");
  a_wide_scale:
    assert property ((driveStateOut == `ST_WIDE)[*2] |-> !loopScaleOut[0] && loopScaleOut != 4'h0)
    else $error("bad wide scale");
  a_final_scale:
    assert property ((driveStateOut == `ST_FINAL)[*3] |-> loopScaleOut inside {[4'h1:4'h8]})
    else $error("bad final scale");
  a_change_grid:
    assert property (moved && gap_r != 0 |-> gap_r % PERIOD == 0) else $error("change off grid");
  a_ready_wait:
    assert property (setupPhase ##1 accessPhase |-> !pready ##1 pready) else $error("bad wait");
endmodule
bind pll_fast_lock_sequencer pll_seq_props #(.DIV_RATIO(DIV_RATIO), .MEAS_CYCLES(MEAS_CYCLES))
  chk (.clk, .resetn, .psel, .penable, .pready, .loopUpOut, .loopDownOut, .loopScaleOut,
  .fastLockUpOut, .fastLockDownOut, .fastLockScaleOut, .driveStateOut);

// file: bench/vco_model.sv
module vco_model (
  // detector side
  input  wire logic clk,
  input  wire logic referenceInput,
  input  wire logic locked,
  output wire logic feedbackInput
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] slowCnt_r = 5'h00;
  logic       slow_r    = 1'h0;
  logic       echo_r    = 1'h0;
  // locked: one clock behind the reference; free: a quarter of its rate
  always @(posedge clk)
  begin
    echo_r    <= referenceInput;
    slowCnt_r <= slowCnt_r + 5'h01;
    if (slowCnt_r == 5'h1F)
      slow_r <= ~slow_r;
  end
  assign feedbackInput = locked ? echo_r : slow_r;
endmodule

// file: bench/testbench.sv
`include "pll_fast_lock_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  refCnt_r = 4'h0, loopScaleOut;
  logic [5:0]  fastLockScaleOut;
  logic [2:0]  driveStateOut;
  logic        pready, pslverr, err, vcoLocked = 1'h0, sawWide, feedbackInput;
  logic        loopUpOut, loopDownOut, fastLockUpOut, fastLockDownOut;
  int          failures = 0, checks = 0;
  wire         referenceInput = refCnt_r[3];
  pll_fast_lock_sequencer dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .referenceInput, .feedbackInput, .loopUpOut, .loopDownOut,
    .loopScaleOut, .fastLockUpOut, .fastLockDownOut, .fastLockScaleOut, .driveStateOut);
  vco_model vco (.clk, .referenceInput, .locked(vcoLocked), .feedbackInput);
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) refCnt_r <= refCnt_r + 4'h1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************
  // bus and waits
  // ****************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    // no cycle count assumed: the watchdog ends a hung slave
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // reference leads feedback by one clock, so only one pump side may pulse
  task automatic checkPump(input logic [1:0] exp);
    logic [1:0] saw;
    saw = 2'h0;
    repeat (40)
    begin
      @(posedge clk);
      saw = saw | {loopUpOut, loopDownOut};
    end
    check(saw, exp);
  endtask
  // state moves only every 152 clocks, so allow several intervals
  task automatic waitState(input logic [2:0] st);
    int n;
    n = 0;
    while (driveStateOut !== st && n < 1000)
    begin
      @(posedge clk);
      n++;
      if (driveStateOut === `ST_WIDE)
        sawWide = 1'h1;
    end
    repeat (2) @(posedge clk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic testReset();
    check(driveStateOut, `ST_FINAL);
    check({loopUpOut, fastLockUpOut, fastLockScaleOut}, 8'h00);
    apb(1'h0, `CTRL_ADDR, 32'h0);
    check(rd, `CTRL_RESET);
    apb(1'h0, 12'h00C, 32'h0);
    check({err, rd[7:0]}, 9'h100);
  endtask
  task automatic testFastLock();
    apb(1'h1, `CTRL_ADDR, 32'h0402004D);
    vcoLocked <= 1'h0;
    waitState(`ST_FDET);
    check(driveStateOut, `ST_FDET);
    check(fastLockScaleOut, 6'h28);
    check({fastLockUpOut, fastLockDownOut, loopUpOut, loopDownOut}, 4'h8);
    vcoLocked <= 1'h1;
    waitState(`ST_WIDE);
    check(driveStateOut, `ST_WIDE);
    check(loopScaleOut, 4'h6);
    waitState(`ST_FINAL);
    check(driveStateOut, `ST_FINAL);
    check(loopScaleOut, 4'h2);
    checkPump(2'h2);
    apb(1'h0, `STATUS_ADDR, 32'h0);
    check(rd, 32'h0000000C);
    apb(1'h0, `EDGECNT_ADDR, 32'h0);
    check(rd[31:2], 30'h00000000);
  endtask
  task automatic testOffsetSkip();
    apb(1'h1, `CTRL_ADDR, 32'h04022463);
    vcoLocked <= 1'h0;
    waitState(`ST_FDET);
    check(fastLockScaleOut, 6'h3C);
    check({fastLockUpOut, fastLockDownOut}, 2'h1);
    sawWide = 1'h0;
    vcoLocked <= 1'h1;
    waitState(`ST_FINAL);
    check({sawWide, driveStateOut}, 4'h4);
    check(loopScaleOut, 4'h8);
    checkPump(2'h1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    testReset();
    testFastLock();
    testOffsetSkip();
    results();
  end
  initial
  begin
    #100us;
    failures++;
    results();
  end
endmodule
